// ===== pkg/cri_defines.svh
/*
  constants for the counter reset / output interlock block.
  assumes inclusion by bare name from the package and the design file.
*/
`ifndef CRI_DEFINES_SVH
`define CRI_DEFINES_SVH
`define CRI_COUNT_W 20
`define CRI_TIME_W 16
`define CRI_EDGE_NONE 2'h0
`define CRI_EDGE_ON 2'h1
`define CRI_EDGE_OFF 2'h2
`define CRI_EDGE_BOTH 2'h3
`define CRI_SRC_MAIN 2'h0
`define CRI_SRC_BATCH 2'h1
`define CRI_SRC_TOTAL 2'h2
`define CRI_CMP_LE 1'h0
`define CRI_CMP_GE 1'h1
`endif

// ===== pkg/cri_pkg.sv
/*
  types for the counter reset / output interlock block.
  assumes cri_defines.svh is on the include path.
*/
`include "cri_defines.svh"
package cri_pkg;
  typedef logic [1:0] cri_edge_sel_t;
  typedef logic [1:0] cri_src_sel_t;
  typedef enum logic [0:0] {
    CRI_OUT_OFF = 1'b0,
    CRI_OUT_ON = 1'b1
  } cri_out_state_t;
endpackage

// ===== verilog/cri_interlock.sv
/*
  counter reset / output interlock: main, batch and totalizer counters,
  the second output with its end conditions, and the counting freeze.
  assumes count, key, remote reset and first output are synchronous to
  i_core_clk; all option bits are plain static inputs.
  option inputs may change at any edge; counters and second output follow at the next edge, the limit and freeze flags at once.
*/
// Contract
// - second output ends on first-output edge choice
// - second output timed end when option set
// - main clears on chosen second-output edges
// - main clears on chosen first-output edges
// - key clears main when enabled and reset
// - remote reset clears main when enabled
// - second set point clears main when enabled
// - batch clears on chosen second-output edges
// - key clears batch when enabled and reset
// - remote reset clears batch when enabled
// - batch set point clears batch when enabled
// - totalizer clears on chosen second-output edges
// - key clears totalizer when enabled and reset
// - remote reset clears totalizer when enabled
// - totalizer set point clears it when enabled
// - first limit compare less or greater equal
// - first output active freezes counting optionally
// - second output active freezes counting optionally
// - selector picks second output activating set point
// - second output ends when condition invalid
`timescale 1ns/1ps
`include "cri_defines.svh"
module cri_interlock #(
  parameter int COUNT_W = `CRI_COUNT_W,
  parameter int TIME_W = `CRI_TIME_W
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // counting and external events
  input wire logic i_count_pulse,
  input wire logic i_key_press,
  input wire logic i_key_is_reset,
  input wire logic i_remote_reset,
  input wire logic i_first_output,
  // limits
  input wire logic [COUNT_W-1:0] i_first_limit_value,
  input wire logic [COUNT_W-1:0] i_second_limit_value,
  input wire logic [COUNT_W-1:0] i_batch_limit_value,
  input wire logic [COUNT_W-1:0] i_total_limit_value,
  // second output options
  input wire cri_pkg::cri_edge_sel_t i_second_output_end_first,
  input wire logic i_second_output_end_timed,
  input wire logic i_second_output_end_invalid,
  input wire logic [TIME_W-1:0] i_second_output_on_time,
  input wire cri_pkg::cri_src_sel_t i_second_output_source_select,
  // main counter options
  input wire cri_pkg::cri_edge_sel_t i_main_clr_second,
  input wire cri_pkg::cri_edge_sel_t i_main_clr_first,
  input wire logic i_main_clr_key,
  input wire logic i_main_clr_remote,
  input wire logic i_main_clr_limit,
  // batch counter options
  input wire cri_pkg::cri_edge_sel_t i_batch_clr_second,
  input wire logic i_batch_clr_key,
  input wire logic i_batch_clr_remote,
  input wire logic i_batch_clr_limit,
  // totalizer options
  input wire cri_pkg::cri_edge_sel_t i_total_clr_second,
  input wire logic i_total_clr_key,
  input wire logic i_total_clr_remote,
  input wire logic i_total_clr_limit,
  // compare and freeze options
  input wire logic i_first_limit_compare_sense,
  input wire logic i_first_output_freeze_option,
  input wire logic i_second_output_freeze_option,
  // status
  output logic [COUNT_W-1:0] o_main_count,
  output logic [COUNT_W-1:0] o_batch_count,
  output logic [COUNT_W-1:0] o_total_count,
  output logic o_first_limit_reached,
  output logic o_second_output,
  output logic o_count_frozen
);
  import cri_pkg::*;

  // elaboration checks on the widths the logic can serve
  if (COUNT_W < 2 || COUNT_W > 32)
  begin : g_count_w_check
    $error("COUNT_W out of range");
  end
  if (TIME_W < 1 || TIME_W > 32)
  begin : g_time_w_check
    $error("TIME_W out of range");
  end

  // edge select applied to on/off pulses
  function automatic logic edge_hit(input cri_edge_sel_t sel, input logic rise, input logic fall);
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  // a set point counts as triggered once the count has reached it
  function automatic logic reached(input logic [COUNT_W-1:0] count, input logic [COUNT_W-1:0] limit);
    reached = (count >= limit);
  endfunction

  logic first_q;
  logic second_q;
  cri_out_state_t second_state_q;
  cri_out_state_t second_state_d;
  logic [TIME_W-1:0] on_timer_q;
  logic key_q;
  logic remote_q;
  logic first_rise, first_fall, second_rise, second_fall;
  logic key_pulse, remote_pulse;
  logic main_hit, batch_hit, total_hit, src_hit;
  logic freeze, count_en;
  logic main_clr, batch_clr, total_clr;
  logic timed_out, second_off;
  logic first_end, src_lost;

  // registered copies of the output states
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      first_q <= 1'b0;
      second_q <= 1'b0;
    end
    else
    begin
      first_q <= i_first_output;
      second_q <= (second_state_q == CRI_OUT_ON);
    end
  end

  // key and remote idle low, so a reset copy of 0 gives no false edge
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      key_q <= 1'b0;
      remote_q <= 1'b0;
    end
    else
    begin
      key_q <= i_key_press;
      remote_q <= i_remote_reset;
    end
  end

  assign first_rise = i_first_output & ~first_q;
  assign first_fall = ~i_first_output & first_q;
  assign second_rise = (second_state_q == CRI_OUT_ON) & ~second_q;
  assign second_fall = (second_state_q == CRI_OUT_OFF) & second_q;
  assign key_pulse = i_key_press & ~key_q & i_key_is_reset;
  assign remote_pulse = i_remote_reset & ~remote_q;

  // set point reach
  assign main_hit = reached(o_main_count, i_second_limit_value);
  assign batch_hit = reached(o_batch_count, i_batch_limit_value);
  assign total_hit = reached(o_total_count, i_total_limit_value);

  // first limit compare sense
  // combinational, follows the count in the same cycle
  always_comb
  begin
    if (i_first_limit_compare_sense == `CRI_CMP_GE)
      o_first_limit_reached = (o_main_count >= i_first_limit_value);
    else
      o_first_limit_reached = (o_main_count <= i_first_limit_value);
  end

  // activating set point select
  // selector value 3 never activates the output
  always_comb
  begin
    unique case (i_second_output_source_select)
      `CRI_SRC_MAIN: src_hit = main_hit;
      `CRI_SRC_BATCH: src_hit = batch_hit;
      `CRI_SRC_TOTAL: src_hit = total_hit;
      default: src_hit = 1'b0;
    endcase
  end

  assign timed_out = i_second_output_end_timed && (on_timer_q >= i_second_output_on_time);

  // first-output edges that end the second output
  assign first_end = edge_hit(i_second_output_end_first, first_rise, first_fall);
  // the selected condition no longer holds
  assign src_lost = i_second_output_end_invalid & ~src_hit;

  assign second_off = first_end | timed_out | src_lost;

  // turn on when the selected set point is reached
  // an ending first-output edge in the same cycle keeps it off
  always_comb
  begin
    second_state_d = second_state_q;
    unique case (second_state_q)
      CRI_OUT_OFF:
      begin
        if (src_hit && !first_end)
          second_state_d = CRI_OUT_ON;
      end
      CRI_OUT_ON:
      begin
        if (second_off)
          second_state_d = CRI_OUT_OFF;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      second_state_q <= CRI_OUT_OFF;
    else
      second_state_q <= second_state_d;
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      on_timer_q <= '0;
    else if (second_state_q == CRI_OUT_OFF)
      on_timer_q <= '0;
    // saturates so a long on-time cannot wrap and restart
    else if (on_timer_q != {TIME_W{1'b1}})
      on_timer_q <= on_timer_q + 1'b1;
  end

  // counting freeze
  // a level: counts arriving while it is high are lost
  assign freeze = (i_first_output_freeze_option & i_first_output)
    | (i_second_output_freeze_option & (second_state_q == CRI_OUT_ON));
  assign count_en = i_count_pulse & ~freeze;

  // main clear sources
  // any enabled source clears; no priority among them
  assign main_clr = edge_hit(i_main_clr_second, second_rise, second_fall)
    | edge_hit(i_main_clr_first, first_rise, first_fall)
    | (i_main_clr_key & key_pulse)
    | (i_main_clr_remote & remote_pulse)
    | (i_main_clr_limit & main_hit);

  assign batch_clr = edge_hit(i_batch_clr_second, second_rise, second_fall)
    | (i_batch_clr_key & key_pulse)
    | (i_batch_clr_remote & remote_pulse)
    | (i_batch_clr_limit & batch_hit);

  assign total_clr = edge_hit(i_total_clr_second, second_rise, second_fall)
    | (i_total_clr_key & key_pulse)
    | (i_total_clr_remote & remote_pulse)
    | (i_total_clr_limit & total_hit);

  // clear beats count
  // counters wrap at the counter width
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      o_main_count <= '0;
    else if (main_clr)
      o_main_count <= '0;
    else if (count_en)
      o_main_count <= o_main_count + 1'b1;
  end

  // batch advances each time the main counter reaches its set point
  // clear wins here too; main count + 1 wraps like the count
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      o_batch_count <= '0;
    else if (batch_clr)
      o_batch_count <= '0;
    else if (count_en && (o_main_count + 1'b1 == i_second_limit_value))
      o_batch_count <= o_batch_count + 1'b1;
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      o_total_count <= '0;
    else if (total_clr)
      o_total_count <= '0;
    else if (count_en)
      o_total_count <= o_total_count + 1'b1;
  end

  // the output is the state flop itself, so it never glitches
  assign o_second_output = (second_state_q == CRI_OUT_ON);
  assign o_count_frozen = freeze;

endmodule

// ===== sim/cri_interlock_properties.sv
/* port checker for cri_interlock.
   assumes it is bound into every cri_interlock instance. */
`timescale 1ns/1ps
module cri_interlock_chk #(parameter int COUNT_W = 20) (
  input wire logic i_core_clk, i_rst, i_first_output, i_key_press, i_key_is_reset, i_remote_reset,
  input wire logic i_first_output_freeze_option, i_second_output_freeze_option, i_first_limit_compare_sense,
  input wire logic i_main_clr_remote, i_total_clr_key, o_second_output, o_count_frozen, o_first_limit_reached,
  input wire logic i_main_clr_limit,
  input wire cri_pkg::cri_edge_sel_t i_second_output_end_first, i_main_clr_second, i_total_clr_second,
  input wire cri_pkg::cri_edge_sel_t i_main_clr_first,
  input wire cri_pkg::cri_src_sel_t i_second_output_source_select,
  input wire logic [COUNT_W-1:0] i_first_limit_value, i_second_limit_value, o_main_count, o_total_count
);
  import cri_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_frz; o_count_frozen == ((i_first_output && i_first_output_freeze_option) ||
    (o_second_output && i_second_output_freeze_option)); endproperty
  a_frz: assert property (p_frz) else $error("freeze level");
  property p_cmp; o_first_limit_reached == (i_first_limit_compare_sense ?
    o_main_count >= i_first_limit_value : o_main_count <= i_first_limit_value); endproperty
  a_cmp: assert property (p_cmp) else $error("limit compare");
  property p_rem; $rose(i_remote_reset) && i_main_clr_remote |=> o_main_count == '0; endproperty
  a_rem: assert property (p_rem) else $error("remote clear");
  property p_key; $rose(i_key_press) && i_key_is_reset && i_total_clr_key |=> o_total_count == '0; endproperty
  a_key: assert property (p_key) else $error("key clear");
  property p_son; $rose(o_second_output) && i_main_clr_second[0] |=> o_main_count == '0; endproperty
  a_son: assert property (p_son) else $error("on edge clear");
  property p_soff; $fell(o_second_output) && i_total_clr_second[1] |=> o_total_count == '0; endproperty
  a_soff: assert property (p_soff) else $error("off edge clear");
  property p_src; i_second_output_source_select == 2'h3 && !o_second_output |=> !o_second_output; endproperty
  a_src: assert property (p_src) else $error("source never");
  property p_end; $rose(i_first_output) && i_second_output_end_first[0] |=> !o_second_output; endproperty
  a_end: assert property (p_end) else $error("first on end");
  property p_fon; $rose(i_first_output) && i_main_clr_first[0] |=> o_main_count == '0; endproperty
  a_fon: assert property (p_fon) else $error("first on edge clear");
  property p_lim; i_main_clr_limit && o_main_count >= i_second_limit_value |=> o_main_count == '0; endproperty
  a_lim: assert property (p_lim) else $error("set point clear");
endmodule
bind cri_interlock cri_interlock_chk #(.COUNT_W(COUNT_W)) u_chk (.*);

// ===== sim/cri_field_model.sv
/* count sensor model: one-cycle count pulses, fast or spaced.
   assumes i_core_clk is the interlock clock. */
`timescale 1ns/1ps
module cri_field_model (
  input wire logic i_core_clk,
  output logic o_pulse
);
  initial o_pulse = 1'h0;
  task automatic pulses(input int n, input int gap);
    repeat (n)
    begin
      @(posedge i_core_clk);
      o_pulse <= 1'h1;
      @(posedge i_core_clk);
      o_pulse <= 1'h0;
      repeat (gap) @(posedge i_core_clk);
    end
  endtask
endmodule

// ===== sim/tb_top.sv
/* self-checking bench for cri_interlock.
   assumes the bound checker and the count sensor model. */
`timescale 1ns/1ps
module tb_top;
  import cri_pkg::*;
  logic i_core_clk = 0, i_rst = 1, i_key_press = 0, i_key_is_reset = 0, i_remote_reset = 0, i_first_output = 0;
  logic i_second_output_end_timed = 0, i_second_output_end_invalid = 0, i_main_clr_key = 0, i_main_clr_remote = 0;
  logic i_main_clr_limit = 0, i_batch_clr_key = 0, i_batch_clr_remote = 0, i_batch_clr_limit = 0;
  logic i_total_clr_key = 0, i_total_clr_remote = 0, i_total_clr_limit = 0, i_first_limit_compare_sense = 0;
  logic i_first_output_freeze_option = 0, i_second_output_freeze_option = 0;
  logic [19:0] i_first_limit_value = 20'h3, i_second_limit_value = 20'hFFFFF;
  logic [19:0] i_batch_limit_value = 20'hFFFFF, i_total_limit_value = 20'hFFFFF;
  logic [15:0] i_second_output_on_time = 16'h5;
  cri_edge_sel_t i_second_output_end_first = 2'h1, i_main_clr_second = 2'h0, i_main_clr_first = 2'h0;
  cri_edge_sel_t i_batch_clr_second = 2'h0, i_total_clr_second = 2'h0;
  cri_src_sel_t i_second_output_source_select = 2'h3;
  logic [19:0] o_main_count, o_batch_count, o_total_count;
  logic o_first_limit_reached, o_second_output, o_count_frozen;
  wire i_count_pulse;
  int errors = 0, compares = 0, cyc = 0;
  cri_interlock dut (.*);
  cri_field_model pm (.i_core_clk(i_core_clk), .o_pulse(i_count_pulse));
  always #25 i_core_clk = ~i_core_clk;
  task automatic give_verdict;
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors = errors + 1;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic t_freeze;
    pm.pulses(3, 0);
    tick(2);
    chk("main", o_main_count, 3);
    chk("total", o_total_count, 3);
    @(posedge i_core_clk);
    i_first_output <= 1;
    i_first_output_freeze_option <= 1;
    tick(1);
    chk("frozen", o_count_frozen, 1);
    pm.pulses(2, 1);
    tick(2);
    chk("held", o_main_count, 3);
    chk("total held", o_total_count, 3);
    @(posedge i_core_clk);
    i_first_output <= 0;
    i_first_output_freeze_option <= 0;
  endtask
  task automatic t_cmp;
    for (int s = 0; s < 2; s++)
      for (int l = 2; l < 5; l++)
      begin
        @(posedge i_core_clk);
        i_first_limit_compare_sense <= s[0];
        i_first_limit_value <= l[19:0];
        tick(1);
        chk("reached", o_first_limit_reached, s ? 3 >= l : 3 <= l);
      end
  endtask
  task automatic t_remote;
    @(posedge i_core_clk);
    i_main_clr_remote <= 1;
    i_remote_reset <= 1;
    tick(2);
    chk("main", o_main_count, 0);
    chk("total", o_total_count, 3);
    @(posedge i_core_clk);
    i_remote_reset <= 0;
  endtask
  task automatic t_key;
    pm.pulses(2, 0);
    @(posedge i_core_clk);
    i_key_is_reset <= 1;
    i_total_clr_key <= 1;
    i_key_press <= 1;
    tick(2);
    chk("main", o_main_count, 2);
    chk("total", o_total_count, 0);
    @(posedge i_core_clk);
    i_key_press <= 0;
  endtask
  task automatic t_second;
    int k;
    @(posedge i_core_clk);
    i_second_output_source_select <= 2'h0;
    i_second_limit_value <= 20'h4;
    i_main_clr_second <= 2'h1;
    i_total_clr_second <= 2'h2;
    i_second_output_end_timed <= 1'b1;
    pm.pulses(2, 0);
    for (k = 0; k < 8 && o_second_output !== 1'b1; k++) tick(1);
    tick(1);
    chk("on", o_second_output, 1);
    chk("main", o_main_count, 0);
    chk("batch", o_batch_count, 1);
    for (k = 0; k < 12 && o_second_output !== 1'b0; k++) tick(1);
    tick(2);
    chk("off", o_second_output, 0);
    chk("total", o_total_count, 0);
  endtask
  task automatic t_limit;
    pm.pulses(2, 0);
    @(posedge i_core_clk);
    i_main_clr_first <= 2'h1;
    i_first_output <= 1'b1;
    tick(2);
    chk("main", o_main_count, 0);
    @(posedge i_core_clk);
    i_first_output <= 1'b0;
    i_main_clr_first <= 2'h0;
    i_main_clr_limit <= 1'b1;
    i_second_output_source_select <= 2'h3;
    pm.pulses(4, 0);
    tick(2);
    chk("main", o_main_count, 0);
    chk("batch", o_batch_count, 2);
    @(posedge i_core_clk);
    i_main_clr_limit <= 1'b0;
    i_batch_clr_limit <= 1'b1;
    i_batch_limit_value <= 20'h2;
    i_total_clr_limit <= 1'b1;
    i_total_limit_value <= 20'h6;
    tick(2);
    chk("batch", o_batch_count, 0);
    chk("total", o_total_count, 0);
    @(posedge i_core_clk);
    i_batch_clr_limit <= 1'b0;
    i_total_clr_limit <= 1'b0;
  endtask
  initial
  begin
    repeat (16) @(posedge i_core_clk);
    i_rst <= 0;
    t_freeze();
    t_cmp();
    t_remote();
    t_key();
    t_second();
    t_limit();
    give_verdict();
  end
endmodule
